// ==== logic/kds_pkg.sv ====
/*
  Package for the kernel diagnostic status display block: widths, key
  positions, error index range, nonvolatile layout, timing, states and the
  nonvolatile write carrier.
  Assumes a single 20 MHz clock shared by every user of the package.
*/
package kds_pkg;

  // clock and timing
  localparam int unsigned KDS_CLK_HZ = 20_000_000;
  localparam int unsigned KDS_FLASH_HALF_MS = 250;
  localparam int unsigned KDS_FLASH_HALF_CYCLES = (KDS_FLASH_HALF_MS * (KDS_CLK_HZ / 1000));

  // front panel keys, same order as the menu lamps, bottom first
  localparam int unsigned KDS_KEY_COUNT = 8;
  localparam int unsigned KDS_FIRST_CLEAR_KEY_POS = 0;
  localparam int unsigned KDS_SECOND_CLEAR_KEY_POS = 1;

  // kernel error index
  localparam int unsigned KDS_ERR_W = 5;
  localparam logic [4:0] KDS_ERR_MIN = 5'h0B;
  localparam logic [4:0] KDS_ERR_MAX = 5'h1F;
  localparam logic [4:0] KDS_ERR_RESET = 5'h00;

  // nonvolatile memory layout
  localparam int unsigned KDS_NV_AW = 8;
  localparam int unsigned KDS_NV_DW = 8;
  localparam logic [7:0] KDS_NV_LAST_ADDR = 8'hFF;
  localparam logic [7:0] KDS_NV_ADDR_POWER_CYCLE_COUNT = 8'hF0;
  localparam logic [7:0] KDS_NV_ADDR_OPERATING_TIME_TOTAL = 8'hF4;
  localparam logic [7:0] KDS_NV_ADDR_CHASSIS_SERIAL_NUMBER = 8'hF8;
  localparam logic [7:0] KDS_NV_DEFAULT_VALUE = 8'h00;

  // sequencer states
  typedef enum logic [5:0] {
    KDS_ST_POWER_ON = 6'h01,
    KDS_ST_KERNEL = 6'h02,
    KDS_ST_FAILED = 6'h04,
    KDS_ST_SCAN = 6'h08,
    KDS_ST_ERASE = 6'h10,
    KDS_ST_DONE = 6'h20
  } kds_state_t;

  typedef struct packed {
    logic we;
    logic [KDS_NV_AW-1:0] addr;
    logic [KDS_NV_DW-1:0] data;
  } kds_nv_wr_t;

endpackage

// ==== logic/kds_status_display.sv ====
/*
  Power-up diagnostic reporting: status lamps, kernel error index on menu
  lamps and probe points, and the two-key nonvolatile erase.
  Assumes the processor side gives one-cycle kernel start/pass/fail pulses
  and a nonvolatile write port that accepts one write every clock.
*/
//
// Summary of operation
// RULE1: after kernel pass, erase only if exactly two clear keys
// RULE2: erase writes default, keeps three protected locations
// RULE3: menu lamps show index, bottom lamp is lsb
// RULE4: lit lamp is one, dark lamp is zero
// RULE5: reported index lies between 0B and 1F; code shows 00 until an index in range is reported
// RULE6: flash while kernel runs, steady on failure
// RULE7: lamps B/A encode power-on, running, failed, finished
// RULE8: probe points carry index msb first, high true
// RULE9: one held index register feeds lamps and probes
`timescale 1ns/1ns
module kds_status_display
  import kds_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = KDS_FLASH_HALF_CYCLES
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // kernel diagnostic events
  input wire logic i_kernel_start,
  input wire logic i_kernel_pass,
  input wire logic i_kernel_fail,
  input wire logic [KDS_ERR_W-1:0] i_kernel_err_index,
  // front panel keys, 1 = closed
  input wire logic [KDS_KEY_COUNT-1:0] i_panel_keys,
  // lamps and probe points
  output logic o_status_lamp_a,
  output logic o_status_lamp_b,
  output logic [KDS_ERR_W-1:0] o_menu_lamps,
  output logic [KDS_ERR_W-1:0] o_error_probe_points,
  // nonvolatile write port
  output kds_nv_wr_t o_nv_wr,
  // progress
  output logic o_erase_busy,
  output logic o_selftest_start
);

  localparam logic [KDS_KEY_COUNT-1:0] CLEAR_COMBO =
    KDS_KEY_COUNT'((1 << KDS_FIRST_CLEAR_KEY_POS) | (1 << KDS_SECOND_CLEAR_KEY_POS));
  localparam logic [31:0] FLASH_LAST = 32'(FLASH_CYCLES - 1);

  kds_state_t state_ff, nxt_state;
  logic [31:0] flash_cnt_ff, nxt_flash_cnt;
  logic blink_ff, nxt_blink;
  logic [KDS_ERR_W-1:0] err_index_ff, nxt_err_index;
  logic [KDS_NV_AW-1:0] erase_addr_ff, nxt_erase_addr;
  logic lamp_a_ff, nxt_lamp_a;
  logic lamp_b_ff, nxt_lamp_b;
  kds_nv_wr_t nv_wr_ff, nxt_nv_wr;
  logic erase_busy_ff, nxt_erase_busy;
  logic selftest_start_ff, nxt_selftest_start;
  logic flash_tick;
  logic addr_protected;
  logic index_valid;

  assign flash_tick = (flash_cnt_ff == FLASH_LAST);
  assign index_valid = (i_kernel_err_index >= KDS_ERR_MIN) && (i_kernel_err_index <= KDS_ERR_MAX); // [RULE5]
  assign addr_protected = (erase_addr_ff == KDS_NV_ADDR_POWER_CYCLE_COUNT) ||
                          (erase_addr_ff == KDS_NV_ADDR_OPERATING_TIME_TOTAL) ||
                          (erase_addr_ff == KDS_NV_ADDR_CHASSIS_SERIAL_NUMBER); // [RULE2]

  always_comb begin
    nxt_state = state_ff;
    nxt_flash_cnt = flash_cnt_ff;
    nxt_blink = blink_ff;
    nxt_err_index = err_index_ff;
    nxt_erase_addr = erase_addr_ff;
    nxt_lamp_a = lamp_a_ff;
    nxt_lamp_b = lamp_b_ff;
    nxt_nv_wr = '0;
    nxt_erase_busy = 1'b0;
    nxt_selftest_start = 1'b0;
    case (state_ff)
      KDS_ST_POWER_ON: begin
        nxt_lamp_a = 1'b1; // [RULE7]
        nxt_lamp_b = 1'b1;
        if (i_kernel_start) begin
          nxt_state = KDS_ST_KERNEL;
          nxt_flash_cnt = '0;
          nxt_blink = 1'b1;
          nxt_lamp_a = 1'b0;
          nxt_lamp_b = 1'b1;
        end
      end
      KDS_ST_KERNEL: begin
        // lamp b blinks, a stays dark: running pattern shown on each lit phase
        nxt_flash_cnt = flash_tick ? '0 : flash_cnt_ff + 32'h00000001;
        nxt_blink = flash_tick ? ~blink_ff : blink_ff; // [RULE6]
        nxt_lamp_a = 1'b0; // [RULE7]
        nxt_lamp_b = nxt_blink;
        if (i_kernel_fail) begin
          // an out-of-range code still shows failure but leaves the index alone
          if (index_valid) begin
            nxt_err_index = i_kernel_err_index; // [RULE5] [RULE9]
          end
          nxt_state = KDS_ST_FAILED;
          nxt_lamp_a = 1'b1; // [RULE6] [RULE7]
          nxt_lamp_b = 1'b0;
        end else if (i_kernel_pass) begin
          nxt_state = KDS_ST_SCAN;
          nxt_lamp_a = 1'b0; // [RULE7]
          nxt_lamp_b = 1'b0;
        end
      end
      KDS_ST_FAILED: begin
        // held until the next power-up; no self-test after a kernel fault
        nxt_lamp_a = 1'b1; // [RULE6]
        nxt_lamp_b = 1'b0;
      end
      KDS_ST_SCAN: begin
        nxt_lamp_a = 1'b0;
        nxt_lamp_b = 1'b0;
        if (i_panel_keys == CLEAR_COMBO) begin // [RULE1]
          nxt_state = KDS_ST_ERASE;
          nxt_erase_addr = '0;
          nxt_erase_busy = 1'b1;
        end else begin
          nxt_state = KDS_ST_DONE;
          nxt_selftest_start = 1'b1;
        end
      end
      KDS_ST_ERASE: begin
        nxt_erase_busy = 1'b1;
        nxt_nv_wr.we = ~addr_protected; // [RULE2]
        nxt_nv_wr.addr = erase_addr_ff;
        nxt_nv_wr.data = KDS_NV_DEFAULT_VALUE;
        nxt_erase_addr = erase_addr_ff + 8'h01;
        if (erase_addr_ff == KDS_NV_LAST_ADDR) begin
          nxt_state = KDS_ST_DONE;
          nxt_erase_busy = 1'b0;
          nxt_selftest_start = 1'b1;
        end
      end
      KDS_ST_DONE: begin
        nxt_lamp_a = 1'b0;
        nxt_lamp_b = 1'b0;
      end
      default: begin
        nxt_state = KDS_ST_POWER_ON;
        nxt_lamp_a = 1'b1;
        nxt_lamp_b = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_ff <= KDS_ST_POWER_ON;
      flash_cnt_ff <= '0;
      blink_ff <= 1'b1;
      err_index_ff <= KDS_ERR_RESET;
      erase_addr_ff <= '0;
      lamp_a_ff <= 1'b1;
      lamp_b_ff <= 1'b1;
      nv_wr_ff <= '0;
      erase_busy_ff <= 1'b0;
      selftest_start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      flash_cnt_ff <= nxt_flash_cnt;
      blink_ff <= nxt_blink;
      err_index_ff <= nxt_err_index;
      erase_addr_ff <= nxt_erase_addr;
      lamp_a_ff <= nxt_lamp_a;
      lamp_b_ff <= nxt_lamp_b;
      nv_wr_ff <= nxt_nv_wr;
      erase_busy_ff <= nxt_erase_busy;
      selftest_start_ff <= nxt_selftest_start;
    end
  end

  // lamp bit i is the i-th lamp from the bottom; probe vector bit 4 is the msb point
  assign o_menu_lamps = err_index_ff; // [RULE3] [RULE4] [RULE9]
  assign o_error_probe_points = err_index_ff; // [RULE8] [RULE9]
  assign o_status_lamp_a = lamp_a_ff;
  assign o_status_lamp_b = lamp_b_ff;
  assign o_nv_wr = nv_wr_ff;
  assign o_erase_busy = erase_busy_ff;
  assign o_selftest_start = selftest_start_ff;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  chk_erase_on_combo: assert property ( // [RULE1]
    (state_ff == KDS_ST_SCAN) |=> (o_erase_busy == ($past(i_panel_keys) == CLEAR_COMBO)))
    else $error("erase start does not match key combination");
  chk_no_erase_start: assert property ( // [RULE1]
    (state_ff == KDS_ST_SCAN && i_panel_keys != CLEAR_COMBO) |=> o_selftest_start && !o_nv_wr.we)
    else $error("self-test not started directly without combo");
  chk_protect_kept: assert property ( // [RULE2]
    o_nv_wr.we |-> (o_nv_wr.addr != KDS_NV_ADDR_POWER_CYCLE_COUNT &&
                    o_nv_wr.addr != KDS_NV_ADDR_OPERATING_TIME_TOTAL &&
                    o_nv_wr.addr != KDS_NV_ADDR_CHASSIS_SERIAL_NUMBER && o_nv_wr.data == KDS_NV_DEFAULT_VALUE))
    else $error("protected location written or wrong default");
  chk_erase_covers: assert property ( // [RULE2]
    (state_ff == KDS_ST_ERASE && !addr_protected) |=> o_nv_wr.we && o_nv_wr.addr == $past(erase_addr_ff))
    else $error("unprotected location skipped by erase");
  chk_lamps_index: assert property ( // [RULE3]
    $rose(state_ff == KDS_ST_FAILED) && $past(index_valid) |->
      o_menu_lamps == $past(i_kernel_err_index) && o_menu_lamps[0] == $past(i_kernel_err_index[0]))
    else $error("menu lamps do not show failing index");
  chk_index_range: assert property ( // [RULE5]
    (o_menu_lamps == KDS_ERR_RESET) || (o_menu_lamps >= KDS_ERR_MIN && o_menu_lamps <= KDS_ERR_MAX))
    else $error("error index out of range");
  chk_fail_steady: assert property ( // [RULE6]
    (state_ff == KDS_ST_FAILED) |-> o_status_lamp_a && !o_status_lamp_b ##1 o_status_lamp_a && !o_status_lamp_b)
    else $error("failure lamps not steady");
  chk_lamp_encoding: assert property ( // [RULE7]
    (state_ff == KDS_ST_KERNEL) |-> !o_status_lamp_a)
    else $error("lamp a lit while kernel running");
  chk_done_dark: assert property ( // [RULE7]
    (state_ff == KDS_ST_DONE) |-> !o_status_lamp_a && !o_status_lamp_b)
    else $error("lamps lit after finish");
  chk_probe_match: assert property ( // [RULE8]
    (o_error_probe_points == o_menu_lamps) &&
      ($stable(o_error_probe_points) || $rose(state_ff == KDS_ST_FAILED)))
    else $error("probe points differ from lamps or drift");
  chk_index_held: assert property ( // [RULE9]
    (state_ff == KDS_ST_FAILED) [*2] |-> $stable(o_menu_lamps))
    else $error("error index changed after failure");

  cov_fail_path: cover property ($rose(state_ff == KDS_ST_FAILED));
  cov_erase_path: cover property ($fell(o_erase_busy) ##1 (state_ff == KDS_ST_DONE));
  cov_plain_start: cover property ((state_ff == KDS_ST_SCAN) ##1 o_selftest_start && !o_erase_busy);
  cov_blink: cover property ((state_ff == KDS_ST_KERNEL) && $fell(o_status_lamp_b));

endmodule

// ==== tb/kds_panel_model.sv ====
/*
  Front panel key model: a technician holding a key combination.
  Assumes the bench changes the request at the falling clock edge.
*/
`timescale 1ns/1ns
module kds_panel_model
  import kds_pkg::*;
(
  // technician request
  input wire logic i_hold,
  input wire logic [KDS_KEY_COUNT-1:0] i_combo,
  // key contacts
  output logic [KDS_KEY_COUNT-1:0] o_panel_keys
);
  // open contacts are pulled to 0
  assign o_panel_keys = i_hold ? i_combo : '0;
endmodule

// ==== tb/test_kds_status_display.sv ====
/*
  Bench for the kernel diagnostic status display: reset, fail, blink and
  key scan / erase scenarios.
  Assumes kds_status_display and kds_panel_model are compiled before it.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
  $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module test_kds_status_display;
  import kds_pkg::*;
  logic i_sys_clk, i_reset, i_kernel_start, i_kernel_pass, i_kernel_fail, hold;
  logic [4:0] i_kernel_err_index, o_menu_lamps, o_error_probe_points;
  logic [7:0] combo, i_panel_keys;
  logic o_status_lamp_a, o_status_lamp_b, o_erase_busy, o_selftest_start;
  kds_nv_wr_t o_nv_wr;
  int num_errors = 0;
  int compares = 0;

  kds_panel_model kds_panel_model_i (.i_hold(hold), .i_combo(combo), .o_panel_keys(i_panel_keys));
  // short blink period keeps the run brief
  kds_status_display #(.FLASH_CYCLES(4)) kds_status_display_i (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_kernel_start(i_kernel_start),
    .i_kernel_pass(i_kernel_pass), .i_kernel_fail(i_kernel_fail),
    .i_kernel_err_index(i_kernel_err_index), .i_panel_keys(i_panel_keys),
    .o_status_lamp_a(o_status_lamp_a), .o_status_lamp_b(o_status_lamp_b),
    .o_menu_lamps(o_menu_lamps), .o_error_probe_points(o_error_probe_points),
    .o_nv_wr(o_nv_wr), .o_erase_busy(o_erase_busy), .o_selftest_start(o_selftest_start));

  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  task give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_sys_clk);
    s = 1'b0;
  endtask

  task do_reset;
    i_reset = 1'b1;
    repeat (10) @(negedge i_sys_clk);
    i_reset = 1'b0;
    @(negedge i_sys_clk);
    `CHK("lamp_a_por", 1'b1, o_status_lamp_a)
    `CHK("lamp_b_por", 1'b1, o_status_lamp_b)
    `CHK("menu_por", 5'h00, o_menu_lamps)
  endtask

  task start_kernel;
    pulse(i_kernel_start);
    @(negedge i_sys_clk);
    `CHK("lamp_a_run", 1'b0, o_status_lamp_a)
    `CHK("lamp_b_run", 1'b1, o_status_lamp_b)
  endtask

  task fail_case(input logic [4:0] idx, input logic [4:0] exp);
    do_reset();
    start_kernel();
    i_kernel_err_index = idx;
    pulse(i_kernel_fail);
    repeat (10) @(negedge i_sys_clk);
    `CHK("lamp_a_fail", 1'b1, o_status_lamp_a)
    `CHK("lamp_b_fail", 1'b0, o_status_lamp_b)
    `CHK("menu_index", exp, o_menu_lamps)
    `CHK("menu_top_lamp", exp[4], o_menu_lamps[4])
    `CHK("probe_index", exp, o_error_probe_points)
  endtask

  task blink_case;
    int tg;
    logic prev;
    tg = 0;
    do_reset();
    start_kernel();
    prev = o_status_lamp_b;
    repeat (20) begin
      @(negedge i_sys_clk);
      if (o_status_lamp_b !== prev) tg++;
      prev = o_status_lamp_b;
      `CHK("lamp_a_blink", 1'b0, o_status_lamp_a)
    end
    `CHK("blink_seen", 1'b1, tg >= 4)
  endtask

  // erase must skip the three kept records and write every other byte once
  task scan_case(input logic [7:0] keys, input logic erase);
    int wr, cyc;
    logic busy_seen, done, kept;
    logic [8:0] next_addr;
    wr = 0;
    busy_seen = 1'b0;
    done = 1'b0;
    next_addr = 9'h000;
    do_reset();
    combo = keys;
    hold = 1'b1;
    start_kernel();
    pulse(i_kernel_pass);
    for (cyc = 0; cyc < 400 && !done; cyc++) begin
      if (o_erase_busy === 1'b1) busy_seen = 1'b1;
      if (o_nv_wr.we === 1'b1) begin
        wr++;
        `CHK("nv_data", KDS_NV_DEFAULT_VALUE, o_nv_wr.data)
        kept = (o_nv_wr.addr inside {KDS_NV_ADDR_POWER_CYCLE_COUNT,
          KDS_NV_ADDR_OPERATING_TIME_TOTAL, KDS_NV_ADDR_CHASSIS_SERIAL_NUMBER});
        `CHK("nv_kept", 1'b0, kept)
        `CHK("nv_order", 1'b1, {1'b0, o_nv_wr.addr} >= next_addr)
        next_addr = {1'b0, o_nv_wr.addr} + 9'h001;
      end
      if (o_selftest_start === 1'b1) done = 1'b1;
      @(negedge i_sys_clk);
    end
    hold = 1'b0;
    if (!done) begin
      num_errors++;
      give_verdict();
    end
    `CHK("start_pulse", 1'b0, o_selftest_start)
    `CHK("erase_busy", erase, busy_seen)
    `CHK("nv_writes", erase ? 253 : 0, wr)
    `CHK("lamp_a_done", 1'b0, o_status_lamp_a)
    `CHK("lamp_b_done", 1'b0, o_status_lamp_b)
  endtask

  initial begin
    i_reset = 1'b1;
    i_kernel_start = 1'b0;
    i_kernel_pass = 1'b0;
    i_kernel_fail = 1'b0;
    i_kernel_err_index = 5'h00;
    hold = 1'b0;
    combo = 8'h00;
    @(negedge i_sys_clk);
    fail_case(5'h12, 5'h12);
    fail_case(5'h0B, 5'h0B);
    fail_case(5'h1F, 5'h1F);
    fail_case(5'h05, 5'h00);
    blink_case();
    scan_case(8'h03, 1'b1);
    scan_case(8'h01, 1'b0);
    scan_case(8'h02, 1'b0);
    scan_case(8'h07, 1'b0);
    scan_case(8'h83, 1'b0);
    give_verdict();
  end
endmodule
